// ---- verilog/acrl_defs.svh ----
// Function
// - Alert line pulled low on state change.
// - Alerting unit returns its own address byte.
// - Start, ARA read, ack, address, ack, PEC, ack, stop.
// - Open-drain arbitration leaves lowest address winning.
// - Address in upper seven bits, lsb free.
// - Sample the address byte actually on bus.
// - Release alert only if sampled byte matches.
// - Software setpoint overrides pin until power cycle.
// - After reset setpoint follows the pin again.
// - Pin high gives 52V, pin low 18V.
// - Enable or interlock released turns output off.
// - RS485 mode ignores the enable pin.
// - Power-good high while output delivered, low before loss.
// - Power-good toggles with 1ms period in overload.
// - Fault low on shutdown or internal fault.
// - Over-temperature warning low 10s before shutdown.
// - Restart and release warning when temperature recovers.
// - Alert stays latched until clear-faults command or a won alert response.
// - PEC is CRC-8, polynomial x^8+x^2+x+1.
`ifndef ACRL_DEFS_SVH
`define ACRL_DEFS_SVH

// ==========================================================================
// Serial bus
`define ACRL_ARA_BYTE 8'h19
`define ACRL_OWN_LSB 1'h1
`define ACRL_BITS_PER_BYTE 4'h8
`define ACRL_PEC_POLY 8'h07
`define ACRL_PEC_INIT 8'h00

// ==========================================================================
// Setpoint, values in 10 mV units, pin levels in mV
`define ACRL_CV_DEFAULT 16'h1450
`define ACRL_CV_MIN 16'h0708
`define ACRL_CV_MAX_LIN 16'h14B4
`define ACRL_VPROG_HIGH_MV 12'h0C80
`define ACRL_VPROG_MIN_MV 12'h0064
`define ACRL_VPROG_TOP_MV 12'h0BB8
`define ACRL_LIN_MUL 18'h0_0023
`define ACRL_LIN_DIV 18'h0_001D

// ==========================================================================
// Timing
`define ACRL_CLK_PERIOD_NS 50
`define ACRL_PG_PERIOD_NS 1000000
`define ACRL_OTW_LEAD_S 10
`define ACRL_CLK_HZ 20000000
`define ACRL_PG_HALF_CYCLES (`ACRL_PG_PERIOD_NS / 2 / `ACRL_CLK_PERIOD_NS)
`define ACRL_OTW_LEAD_CYCLES (`ACRL_OTW_LEAD_S * `ACRL_CLK_HZ)

`endif

// ---- verilog/acrl_pkg.sv ----
package acrl_pkg;

	// ======================================================================
	// Alert response sequencer states
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_ADDR_ACK = 7'h04,
		ST_TX_ADDR = 7'h08,
		ST_MST_ACK1 = 7'h10,
		ST_TX_PEC = 7'h20,
		ST_MST_ACK2 = 7'h40
	} acrl_state_t;

	// ======================================================================
	// Control and status pins, synchronised as one group
	typedef struct packed {
		logic overtemp;
		logic ov_shutdown;
		logic internal_fault;
		logic overload;
		logic reg_loss;
		logic on_off_n;
		logic interlock_n;
		logic rs485;
	} acrl_pins_t;

endpackage

// ---- verilog/acrl_link.sv ----
`timescale 1ns/1ps
`include "acrl_defs.svh"
module acrl_link
(
	input wire logic i_scl, // Serial clock from the master
	input wire logic i_rst, // Asynchronous frame reset, high
	input wire logic i_sda, // Serial data as seen on the bus
	output logic [7:0] o_byte, // Last byte sampled on the bus
	output logic o_byte_tgl // Flips once per completed byte
);

	// ======================================================================
	// Byte capture on the serial clock
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic [7:0] sh_reg;
	logic [7:0] sh_next;
	logic [7:0] byte_reg;
	logic [7:0] byte_next;
	logic tgl_reg;
	logic tgl_next;

	always_comb
	begin
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		byte_next = byte_reg;
		tgl_next = tgl_reg;
		if (cnt_reg == `ACRL_BITS_PER_BYTE)
		begin
			cnt_next = 4'h0;
		end
		else
		begin
			sh_next = {sh_reg[6:0], i_sda};
			cnt_next = cnt_reg + 4'h1;
			if (cnt_reg == `ACRL_BITS_PER_BYTE - 4'h1)
			begin
				byte_next = {sh_reg[6:0], i_sda};
				tgl_next = ~tgl_reg;
			end
		end
	end

	// The frame start clears the counter; the clock only runs inside frames.
	always_ff @(posedge i_scl or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			byte_reg <= 8'h00;
			tgl_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			byte_reg <= byte_next;
			tgl_reg <= tgl_next;
		end
	end

	assign o_byte = byte_reg;
	assign o_byte_tgl = tgl_reg;

endmodule

// ---- verilog/acrl_top.sv ----
`timescale 1ns/1ps
`include "acrl_defs.svh"
module acrl_top #(
	parameter int unsigned PG_HALF_CYCLES = `ACRL_PG_HALF_CYCLES,
	parameter int unsigned OTW_LEAD_CYCLES = `ACRL_OTW_LEAD_CYCLES
)(
	input wire logic I_CLK, // System clock, 20 MHz
	input wire logic I_RESET, // Synchronous reset, bias power cycle
	input wire logic I_SCL, // Serial clock pin, link clock
	input wire logic I_SDA, // Serial data pin level
	output logic O_SDA_OUT, // Serial data drive value, always low
	output logic O_SDA_OE, // Serial data pulled low when high
	input wire logic [6:0] I_OWN_ADDR, // Own 7-bit bus address
	input wire logic I_STATE_CHANGE, // Pulse: internal state changed
	input wire logic I_CLEAR_FAULTS, // Pulse: clear-faults command
	input wire logic I_SW_SET_STB, // Pulse: software setpoint command
	input wire logic [15:0] I_SW_SET_CV, // Software setpoint, 10 mV units
	input wire logic [11:0] I_VPROG_MV, // Setpoint pin level in mV
	input wire logic I_ON_OFF_N, // Output enable pin, low is on
	input wire logic I_INTERLOCK_N, // Interlock pin, low is engaged
	input wire logic I_RS485_MODE, // Protocol pin selects RS485
	input wire logic I_OVERTEMP, // Over-temperature condition
	input wire logic I_OV_SHUTDOWN, // Over-voltage shutdown
	input wire logic I_INTERNAL_FAULT, // Internal fault, needs replacement
	input wire logic I_OVERLOAD, // Output in overload
	input wire logic I_REG_LOSS, // Output about to leave regulation
	output logic O_ALERT_N_OUT, // Alert drive value, always low
	output logic O_ALERT_N_OE, // Alert pulled low when high
	output logic O_FAULT_N_OUT, // Fault drive value, always low
	output logic O_FAULT_N_OE, // Fault pulled low when high
	output logic O_OVERTEMP_WARNING_N_OUT, // Warning drive value, always low
	output logic O_OVERTEMP_WARNING_N_OE, // Warning pulled low when high
	output logic O_POWER_GOOD_WARNING_N_OUT, // Power-good drive value, low
	output logic O_POWER_GOOD_WARNING_N_OE, // Power-good pulled low when high
	output logic O_MAIN_ON, // Main output switched on
	output logic [15:0] O_SETPOINT_CV // Output setpoint, 10 mV units
);

	localparam int OTW_W = $clog2(OTW_LEAD_CYCLES + 1);
	localparam int PG_W = $clog2(PG_HALF_CYCLES + 1);

	if (PG_HALF_CYCLES < 1 || OTW_LEAD_CYCLES < 1)
	begin : g_check
		$error("Timing counts must be at least one cycle.");
	end

	// ======================================================================
	// Pin synchronisers
	acrl_pkg::acrl_pins_t pin_s1;
	acrl_pkg::acrl_pins_t pin_s2;
	logic [1:0] bus_s1;
	logic [1:0] bus_s2;
	logic [1:0] bus_s3;
	logic [2:0] tgl_sync;
	logic [7:0] link_byte;
	logic link_tgl;
	logic od_low_reg;

	always_ff @(posedge I_CLK)
	begin
		pin_s1 <= {I_OVERTEMP, I_OV_SHUTDOWN, I_INTERNAL_FAULT, I_OVERLOAD,
			I_REG_LOSS, I_ON_OFF_N, I_INTERLOCK_N, I_RS485_MODE};
		pin_s2 <= pin_s1;
		bus_s1 <= {I_SDA, I_SCL};
		bus_s2 <= bus_s1;
		bus_s3 <= bus_s2;
		tgl_sync <= {tgl_sync[1:0], link_tgl};
		od_low_reg <= 1'b0;
	end

	wire scl_s = bus_s2[0];
	wire sda_s = bus_s2[1];
	wire scl_rise = scl_s & ~bus_s3[0];
	wire scl_fall = ~scl_s & bus_s3[0];
	wire bus_start = scl_s & bus_s3[0] & ~sda_s & bus_s3[1];
	wire bus_stop = scl_s & bus_s3[0] & sda_s & ~bus_s3[1];
	wire link_evt = tgl_sync[2] ^ tgl_sync[1];

	// ======================================================================
	// Link side byte capture
	logic link_rst_reg;

	acrl_link u_link (
		.i_scl(I_SCL),
		.i_rst(link_rst_reg),
		.i_sda(I_SDA),
		.o_byte(link_byte),
		.o_byte_tgl(link_tgl)
	);

	function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++)
		begin
			c = c[7] ? ((c << 1) ^ `ACRL_PEC_POLY) : (c << 1);
		end
		return c;
	endfunction

	// ======================================================================
	// Alert response sequencer
	acrl_pkg::acrl_state_t st_reg;
	acrl_pkg::acrl_state_t st_next;
	logic [3:0] bit_cnt_reg;
	logic [3:0] bit_cnt_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [7:0] tx_reg;
	logic [7:0] tx_next;
	logic [7:0] crc_reg;
	logic [7:0] crc_next;
	logic sda_drv_reg;
	logic sda_drv_next;
	logic arb_lost_reg;
	logic arb_lost_next;
	logic won_reg;
	logic won_next;
	logic win_evt;
	logic alert_reg;

	always_comb
	begin
		st_next = st_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next = shift_reg;
		tx_next = tx_reg;
		crc_next = crc_reg;
		sda_drv_next = sda_drv_reg;
		arb_lost_next = arb_lost_reg;
		won_next = won_reg;
		win_evt = 1'b0;
		if (bus_start)
		begin
			st_next = acrl_pkg::ST_ADDR;
			bit_cnt_next = 4'h0;
			sda_drv_next = 1'b0;
		end
		else if (bus_stop)
		begin
			st_next = acrl_pkg::ST_IDLE;
			sda_drv_next = 1'b0;
		end
		else
		begin
			unique case (st_reg)
				acrl_pkg::ST_IDLE:
				begin
					sda_drv_next = 1'b0;
				end
				acrl_pkg::ST_ADDR:
				begin
					if (scl_rise)
					begin
						shift_next = {shift_reg[6:0], sda_s};
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end
					else if (scl_fall && bit_cnt_reg == `ACRL_BITS_PER_BYTE)
					begin
						if (shift_reg == `ACRL_ARA_BYTE && alert_reg)
						begin
							sda_drv_next = 1'b1;
							st_next = acrl_pkg::ST_ADDR_ACK;
						end
						else
						begin
							st_next = acrl_pkg::ST_IDLE;
						end
					end
				end
				acrl_pkg::ST_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						tx_next = {I_OWN_ADDR, `ACRL_OWN_LSB};
						sda_drv_next = ~I_OWN_ADDR[6];
						bit_cnt_next = 4'h0;
						arb_lost_next = 1'b0;
						won_next = 1'b0;
						crc_next = crc8(`ACRL_PEC_INIT, `ACRL_ARA_BYTE);
						st_next = acrl_pkg::ST_TX_ADDR;
					end
				end
				acrl_pkg::ST_TX_ADDR, acrl_pkg::ST_TX_PEC:
				begin
					if (scl_rise)
					begin
						bit_cnt_next = bit_cnt_reg + 4'h1;
						if (tx_reg[7] && !sda_s)
						begin
							arb_lost_next = 1'b1;
						end
					end
					else if (scl_fall)
					begin
						if (bit_cnt_reg == `ACRL_BITS_PER_BYTE)
						begin
							sda_drv_next = 1'b0;
							st_next = (st_reg == acrl_pkg::ST_TX_ADDR) ?
								acrl_pkg::ST_MST_ACK1 : acrl_pkg::ST_MST_ACK2;
						end
						else
						begin
							tx_next = {tx_reg[6:0], 1'b0};
							sda_drv_next = ~arb_lost_reg & ~tx_reg[6];
						end
					end
					// The byte toggle arrives while the last address bit is still high.
					if (link_evt && st_reg == acrl_pkg::ST_TX_ADDR)
					begin
						crc_next = crc8(crc_reg, link_byte);
						if (link_byte[7:1] == I_OWN_ADDR)
						begin
							won_next = 1'b1;
							win_evt = 1'b1;
						end
					end
				end
				acrl_pkg::ST_MST_ACK1:
				begin
					if (scl_fall)
					begin
						if (won_reg)
						begin
							tx_next = crc_reg;
							sda_drv_next = ~crc_reg[7];
							bit_cnt_next = 4'h0;
							st_next = acrl_pkg::ST_TX_PEC;
						end
						else
						begin
							st_next = acrl_pkg::ST_IDLE;
						end
					end
				end
				acrl_pkg::ST_MST_ACK2:
				begin
					if (scl_fall)
					begin
						st_next = acrl_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			st_reg <= acrl_pkg::ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			crc_reg <= 8'h00;
			sda_drv_reg <= 1'b0;
			arb_lost_reg <= 1'b0;
			won_reg <= 1'b0;
			link_rst_reg <= 1'b1;
		end
		else
		begin
			st_reg <= st_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			tx_reg <= tx_next;
			crc_reg <= crc_next;
			sda_drv_reg <= sda_drv_next;
			arb_lost_reg <= arb_lost_next;
			won_reg <= won_next;
			link_rst_reg <= bus_start;
		end
	end

	// ======================================================================
	// Alert latch; a new event wins over any clear in the same cycle.
	logic alert_next;

	always_comb
	begin
		alert_next = I_STATE_CHANGE | (alert_reg & ~I_CLEAR_FAULTS & ~win_evt);
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			alert_reg <= 1'b0;
		end
		else
		begin
			alert_reg <= alert_next;
		end
	end

	// ======================================================================
	// Setpoint, output enable and status pins
	logic sw_mode_reg;
	logic sw_mode_next;
	logic [15:0] cv_reg;
	logic [15:0] cv_next;
	logic [15:0] hw_cv;
	logic [17:0] lin;
	logic main_on_reg;
	logic main_on_next;
	logic ot_shut_reg;
	logic ot_shut_next;
	logic [OTW_W-1:0] ot_cnt_reg;
	logic [OTW_W-1:0] ot_cnt_next;
	logic [PG_W-1:0] pg_cnt_reg;
	logic [PG_W-1:0] pg_cnt_next;
	logic pg_oe_reg;
	logic pg_oe_next;
	logic fault_reg;
	logic fault_next;
	logic otw_reg;
	logic otw_next;

	always_comb
	begin
		lin = 18'(I_VPROG_MV - `ACRL_VPROG_MIN_MV) * `ACRL_LIN_MUL / `ACRL_LIN_DIV;
		if (I_VPROG_MV >= `ACRL_VPROG_HIGH_MV)
			hw_cv = `ACRL_CV_DEFAULT;
		else if (I_VPROG_MV < `ACRL_VPROG_MIN_MV)
			hw_cv = `ACRL_CV_MIN;
		else if (I_VPROG_MV > `ACRL_VPROG_TOP_MV)
			hw_cv = `ACRL_CV_MAX_LIN;
		else
			hw_cv = `ACRL_CV_MIN + lin[15:0];
		sw_mode_next = sw_mode_reg | I_SW_SET_STB;
		if (I_SW_SET_STB)
			cv_next = I_SW_SET_CV;
		else if (!sw_mode_reg)
			cv_next = hw_cv;
		else
			cv_next = cv_reg;
		ot_cnt_next = ot_cnt_reg;
		ot_shut_next = ot_shut_reg;
		if (!pin_s2.overtemp)
		begin
			ot_cnt_next = '0;
			ot_shut_next = 1'b0;
		end
		else if (!ot_shut_reg)
		begin
			if (ot_cnt_reg == OTW_W'(OTW_LEAD_CYCLES - 1))
				ot_shut_next = 1'b1;
			else
				ot_cnt_next = ot_cnt_reg + 1'b1;
		end
		otw_next = pin_s2.overtemp;
		fault_next = ot_shut_reg | pin_s2.ov_shutdown | pin_s2.internal_fault;
		// An enable pin held low switches on; RS485 mode skips it.
		main_on_next = ~pin_s2.interlock_n & (pin_s2.rs485 | ~pin_s2.on_off_n)
			& ~fault_next;
		pg_cnt_next = '0;
		pg_oe_next = ~main_on_reg | pin_s2.reg_loss;
		if (pin_s2.overload)
		begin
			pg_oe_next = pg_oe_reg;
			pg_cnt_next = pg_cnt_reg + 1'b1;
			if (pg_cnt_reg == PG_W'(PG_HALF_CYCLES - 1))
			begin
				pg_cnt_next = '0;
				pg_oe_next = ~pg_oe_reg;
			end
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			sw_mode_reg <= 1'b0;
			cv_reg <= `ACRL_CV_DEFAULT;
			main_on_reg <= 1'b0;
			ot_shut_reg <= 1'b0;
			ot_cnt_reg <= '0;
			pg_cnt_reg <= '0;
			pg_oe_reg <= 1'b1;
			fault_reg <= 1'b0;
			otw_reg <= 1'b0;
		end
		else
		begin
			sw_mode_reg <= sw_mode_next;
			cv_reg <= cv_next;
			main_on_reg <= main_on_next;
			ot_shut_reg <= ot_shut_next;
			ot_cnt_reg <= ot_cnt_next;
			pg_cnt_reg <= pg_cnt_next;
			pg_oe_reg <= pg_oe_next;
			fault_reg <= fault_next;
			otw_reg <= otw_next;
		end
	end

	assign O_SDA_OUT = od_low_reg;
	assign O_SDA_OE = sda_drv_reg;
	assign O_ALERT_N_OUT = od_low_reg;
	assign O_ALERT_N_OE = alert_reg;
	assign O_FAULT_N_OUT = od_low_reg;
	assign O_FAULT_N_OE = fault_reg;
	assign O_OVERTEMP_WARNING_N_OUT = od_low_reg;
	assign O_OVERTEMP_WARNING_N_OE = otw_reg;
	assign O_POWER_GOOD_WARNING_N_OUT = od_low_reg;
	assign O_POWER_GOOD_WARNING_N_OE = pg_oe_reg;
	assign O_MAIN_ON = main_on_reg;
	assign O_SETPOINT_CV = cv_reg;

	// ======================================================================
	// Checks
	sequence s_ara_hit;
		st_reg == acrl_pkg::ST_ADDR && scl_fall && bit_cnt_reg == `ACRL_BITS_PER_BYTE
			&& shift_reg == `ACRL_ARA_BYTE && alert_reg && !bus_start && !bus_stop;
	endsequence
	sequence s_ack_driven;
		O_SDA_OE && st_reg == acrl_pkg::ST_ADDR_ACK;
	endsequence

	property p_alert_set;
		@(posedge I_CLK) disable iff (I_RESET) I_STATE_CHANGE |=> O_ALERT_N_OE;
	endproperty
	a_alert_set: assert property (p_alert_set) else $error("Alert not raised.");
	property p_alert_clear;
		@(posedge I_CLK) disable iff (I_RESET)
			(I_CLEAR_FAULTS && !I_STATE_CHANGE) |=> !O_ALERT_N_OE;
	endproperty
	a_alert_clear: assert property (p_alert_clear) else $error("Alert not cleared.");
	property p_ara_ack;
		@(posedge I_CLK) disable iff (I_RESET) s_ara_hit |=> s_ack_driven;
	endproperty
	a_ara_ack: assert property (p_ara_ack) else $error("Alert response not acked.");
	property p_win_release;
		@(posedge I_CLK) disable iff (I_RESET)
			(win_evt && !I_STATE_CHANGE) |=> !O_ALERT_N_OE ##1 won_reg;
	endproperty
	a_win_release: assert property (p_win_release) else $error("Winner kept alert.");
	property p_lost_quiet;
		@(posedge I_CLK) disable iff (I_RESET)
			(arb_lost_reg && st_reg == acrl_pkg::ST_TX_ADDR && scl_fall) |=> !O_SDA_OE;
	endproperty
	a_lost_quiet: assert property (p_lost_quiet) else $error("Loser drives data.");
	property p_sw_hold;
		@(posedge I_CLK) disable iff (I_RESET)
			sw_mode_reg && !I_SW_SET_STB |=> $stable(O_SETPOINT_CV);
	endproperty
	a_sw_hold: assert property (p_sw_hold) else $error("Pin moved setpoint.");
	property p_pin_high;
		@(posedge I_CLK) disable iff (I_RESET)
			(!sw_mode_reg && !I_SW_SET_STB && I_VPROG_MV >= `ACRL_VPROG_HIGH_MV)
			|=> O_SETPOINT_CV == `ACRL_CV_DEFAULT;
	endproperty
	a_pin_high: assert property (p_pin_high) else $error("Default setpoint missed.");
	property p_interlock_off;
		@(posedge I_CLK) disable iff (I_RESET) I_INTERLOCK_N [*3] |=> !O_MAIN_ON;
	endproperty
	a_interlock_off: assert property (p_interlock_off) else $error("Output stayed on.");
	property p_fault;
		@(posedge I_CLK) disable iff (I_RESET) I_OV_SHUTDOWN [*3] |=> O_FAULT_N_OE;
	endproperty
	a_fault: assert property (p_fault) else $error("Fault not signalled.");
	property p_ot_shut;
		@(posedge I_CLK) disable iff (I_RESET)
			(pin_s2.overtemp && !ot_shut_reg && ot_cnt_reg == OTW_W'(OTW_LEAD_CYCLES - 1))
			|=> ot_shut_reg && O_OVERTEMP_WARNING_N_OE ##1 !O_MAIN_ON;
	endproperty
	a_ot_shut: assert property (p_ot_shut) else $error("Shutdown timing wrong.");
	property p_pg_toggle;
		@(posedge I_CLK) disable iff (I_RESET)
			(pin_s2.overload && pg_cnt_reg == PG_W'(PG_HALF_CYCLES - 1))
			|=> O_POWER_GOOD_WARNING_N_OE != $past(O_POWER_GOOD_WARNING_N_OE);
	endproperty
	a_pg_toggle: assert property (p_pg_toggle) else $error("Overload pulse missing.");

endmodule

// ---- verif/acrl_host.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Bus master model: clock only inside frames, data open-drain.
module acrl_host #(
	parameter int HALF = 8
)(
	input wire logic i_lclk, // Link timebase
	input wire logic i_sda, // Wired data line level
	output logic o_scl, // Serial clock, idle high
	output logic o_sda_oe // High pulls data low
);
	initial
	begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge i_lclk);
	endtask
	task automatic bit_io(input logic v, output logic r);
		wt(HALF / 2);
		o_sda_oe <= !v;
		wt(HALF / 2);
		o_scl <= 1'b1;
		wt(HALF / 2);
		r = i_sda;
		wt(HALF / 2);
		o_scl <= 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] v, output logic [7:0] r);
		logic b;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(v[i], b);
			r[i] = b;
		end
	endtask
	// A whole alert response read; the caller repeats it while alert stays low.
	task automatic ara(output logic ack, output logic [7:0] adr, output logic [7:0] pec);
		logic r;
		logic [7:0] d;
		wt(HALF);
		o_sda_oe <= 1'b1;
		wt(HALF);
		o_scl <= 1'b0;
		byte_io(8'h19, d);
		bit_io(1'b1, r);
		ack = !r;
		byte_io(8'hFF, adr);
		bit_io(1'b0, r);
		byte_io(8'hFF, pec);
		bit_io(1'b0, r);
		wt(HALF / 2);
		o_sda_oe <= 1'b1;
		wt(HALF / 2);
		o_scl <= 1'b1;
		wt(HALF);
		o_sda_oe <= 1'b0;
	endtask
endmodule

// ---- verif/acrl_bench.sv ----
`timescale 1ns/1ps
module acrl_bench;
	logic clk, lclk, rst, scl, h_oe, sda, ack, prev, clr, stb;
	logic [1:0] chg, s_out, s_oe, a_out, a_oe, f_out, f_oe, w_out, w_oe, p_out, p_oe, on;
	logic onoff_n, ilock_n, rs485, ot, ov, intf, ovl, loss;
	logic [6:0] own [2];
	logic [15:0] cv [2];
	logic [15:0] sw_cv;
	logic [11:0] mv;
	logic [7:0] adr, pec;
	int fails, comparisons, cnt, n, lo, a0, a1;
	int pend[$];
	int mvs[$] = {0, 99, 100, 1550, 3000, 3100, 3199, 3200, 4095};
	assign sda = !(|s_oe) && !h_oe;
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		lclk = 1'b0;
		#7;
		forever #24 lclk = ~lclk;
	end
	acrl_host u_acrl_host (.i_lclk(lclk), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
	for (genvar k = 0; k < 2; k++)
	begin : g_unit
		acrl_top #(.PG_HALF_CYCLES(4), .OTW_LEAD_CYCLES(20)) u_acrl_top (
			.I_CLK(clk), .I_RESET(rst), .I_SCL(scl), .I_SDA(sda),
			.O_SDA_OUT(s_out[k]), .O_SDA_OE(s_oe[k]), .I_OWN_ADDR(own[k]),
			.I_STATE_CHANGE(chg[k]), .I_CLEAR_FAULTS(clr), .I_SW_SET_STB(stb),
			.I_SW_SET_CV(sw_cv), .I_VPROG_MV(mv), .I_ON_OFF_N(onoff_n),
			.I_INTERLOCK_N(ilock_n), .I_RS485_MODE(rs485), .I_OVERTEMP(ot),
			.I_OV_SHUTDOWN(ov), .I_INTERNAL_FAULT(intf), .I_OVERLOAD(ovl),
			.I_REG_LOSS(loss), .O_ALERT_N_OUT(a_out[k]), .O_ALERT_N_OE(a_oe[k]),
			.O_FAULT_N_OUT(f_out[k]), .O_FAULT_N_OE(f_oe[k]),
			.O_OVERTEMP_WARNING_N_OUT(w_out[k]), .O_OVERTEMP_WARNING_N_OE(w_oe[k]),
			.O_POWER_GOOD_WARNING_N_OUT(p_out[k]), .O_POWER_GOOD_WARNING_N_OE(p_oe[k]),
			.O_MAIN_ON(on[k]), .O_SETPOINT_CV(cv[k])
		);
	end
	// ======================================================================
	// Reference model and helpers
	function automatic int exp_cv(input int m);
		if (m >= 3200) return 5200;
		if (m < 100) return 1800;
		if (m <= 3000) return 1800 + (m - 100) * 35 / 29;
		return 5300;
	endfunction
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	task automatic tick(input int t);
		repeat (t) @(posedge clk);
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#2000000;
		fails++;
		report_and_stop();
	end
	// ======================================================================
	// Main sequence
	initial
	begin
		{rst, chg, clr, stb, sw_cv, mv} = {1'b1, 2'b00, 1'b0, 1'b0, 16'h0000, 12'h0CE4};
		{onoff_n, ilock_n, rs485, ot, ov, intf, ovl, loss} = 8'hC0;
		own[0] = 7'h00;
		own[1] = 7'h00;
		fails = 0;
		comparisons = 0;
		void'($urandom(11740));
		tick(8);
		check(cv[0], 16'h1450);
		check({s_out, a_out, f_out, w_out, p_out}, 10'h000);
		rst <= 1'b0;
		repeat (4) mvs.push_back($urandom_range(4095));
		foreach (mvs[i])
		begin
			mv <= 12'(mvs[i]);
			tick(3);
			check(cv[0], 16'(exp_cv(mvs[i])));
		end
		for (int m = 0; m < 8; m++)
		begin
			{rs485, ilock_n, onoff_n} <= 3'(m);
			tick(6);
			check(on[0], !m[1] && (m[2] || !m[0]));
			check(p_oe[0], !(!m[1] && (m[2] || !m[0])));
		end
		{rs485, ilock_n, onoff_n} <= 3'b000;
		for (int j = 1; j < 3; j++)
		begin
			{intf, ov} <= 2'(j);
			tick(6);
			check({f_oe[0], on[0]}, 2'b10);
		end
		{intf, ov} <= 2'b00;
		ot <= 1'b1;
		tick(6);
		check({w_oe[0], f_oe[0], on[0]}, 3'b101);
		tick(30);
		check({w_oe[0], f_oe[0], on[0]}, 3'b110);
		ot <= 1'b0;
		tick(6);
		check({w_oe[0], f_oe[0], on[0]}, 3'b001);
		loss <= 1'b1;
		tick(6);
		check(p_oe[0], 1'b1);
		{loss, ovl} <= 2'b01;
		tick(6);
		cnt = 0;
		prev = p_oe[0];
		repeat (40)
		begin
			@(posedge clk);
			if (p_oe[0] !== prev) cnt++;
			prev = p_oe[0];
		end
		check(cnt >= 9 && cnt <= 11, 1'b1);
		ovl <= 1'b0;
		a0 = $urandom_range(127);
		a1 = (a0 + 1 + $urandom_range(125)) % 128;
		own[0] <= 7'(a0);
		own[1] <= 7'(a1);
		chg <= 2'b11;
		tick(1);
		chg <= 2'b00;
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
		tick(2);
		check(a_oe, 2'b00);
		chg <= 2'b11;
		tick(1);
		chg <= 2'b00;
		tick(12);
		check(a_oe, 2'b11);
		pend = {a0, a1};
		pend.sort();
		lo = (a0 < a1) ? 0 : 1;
		n = 0;
		while (a_oe !== 2'b00 && n < 3)
		begin
			u_acrl_host.ara(ack, adr, pec);
			tick(2);
			check(ack, 1'b1);
			check(adr, {pend[n][6:0], 1'b1});
			check(pec, crc8({8'h19, pend[n][6:0], 1'b1}));
			check(a_oe, n ? 2'b00 : 2'(1 << (1 - lo)));
			n++;
		end
		check(n, 2);
		u_acrl_host.ara(ack, adr, pec);
		check({ack, adr}, 9'h0FF);
		tick(1);
		sw_cv <= 16'(1800 + $urandom_range(4000));
		stb <= 1'b1;
		tick(1);
		stb <= 1'b0;
		mv <= 12'h0000;
		tick(3);
		check(cv[0], sw_cv);
		check(cv[1], sw_cv);
		rst <= 1'b1;
		tick(8);
		rst <= 1'b0;
		tick(3);
		check(cv[0], 16'h0708);
		report_and_stop();
	end
endmodule
